// ==== verilog/accu_clear_compare.sv ====
// Accumulator clear, compare and magnitude compare unit with APB registers
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/10ps
module accu_clear_compare
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic [6:0] condition_flags,
  output logic flags_valid
);
  import accu_pkg::*;

  accu_alu_if alu ();
  accu_state_t state_reg;
  logic [23:0] data_reg [0:NUM_DATA-1];
  logic [23:0] instr_reg;
  logic [5:0] move_reg;
  logic [6:0] flags_reg;
  accu_scale_t scale_reg;
  logic [NUM_IRQ-1:0] irq_stat_reg;
  logic [NUM_IRQ-1:0] irq_en_reg;
  logic [4:0] cnt_reg;
  logic [4:0] total_reg;
  logic [1:0] words_reg;
  logic illegal_reg;
  accu_op_t op_reg;
  logic dsel_reg;
  logic load_reg;
  logic [55:0] s1_reg;
  logic [55:0] s2_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  logic valid_reg;

  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic start;
  logic mapped;
  logic data_hit;
  logic [3:0] data_idx;
  logic [7:0] data_ofs;
  logic [7:0] low_byte;
  accu_op_t op_dec;
  logic [55:0] acc_a;
  logic [55:0] acc_b;
  logic [55:0] word_ext;
  logic [55:0] s1_sel;
  logic [55:0] s2_sel;
  logic [4:0] total_next;
  logic [NUM_IRQ-1:0] irq_events;
  logic [31:0] rd_data;
  logic done;
  logic cmp_done;
  logic [6:0] flags_next;

  accu_cmp_unit u_cmp
  (
    .pclk(pclk),
    .presetn(presetn),
    .alu(alu.unit)
  );

  // ===========================================================
  // APB decode: one setup cycle, one access cycle, no wait states
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready_reg & pwrite;
  assign rd_acc = setup & ~pwrite;
  assign data_ofs = paddr - OFS_DATA;
  assign data_idx = data_ofs[5:2];
  // Upper offset bits are checked too, so high addresses do not alias the data words
  assign data_hit = (paddr >= OFS_DATA) && (data_ofs[7:6] == 2'h0) && (data_idx < 4'(NUM_DATA))
                    && (paddr[1:0] == 2'h0);
  assign mapped = data_hit || ((paddr <= OFS_IRQ_EN) && (paddr[1:0] == 2'h0));
  assign done = (state_reg == ST_DONE);
  assign cmp_done = done && (op_reg == OP_CMP || op_reg == OP_MAG);

  // ===========================================================
  // Opcode decode of the low byte; the move field above is not ours
  assign low_byte = pwdata[7:0];
  always_comb
  begin
    op_dec = OP_NONE;
    if (low_byte[7:4] == 4'h1 && low_byte[2:0] == 3'h3)
      op_dec = OP_CLR;
    else if (!low_byte[7] && low_byte[2:0] == 3'h5)
      op_dec = OP_CMP;
    else if (!low_byte[7] && low_byte[2:0] == 3'h7)
      op_dec = OP_MAG;
    // Pairs 001x and 01xx have no operands defined
    if (op_dec != OP_CLR && op_dec != OP_NONE && low_byte[6:3] != 4'h0 && low_byte[6:3] != 4'h1
        && !low_byte[6])
      op_dec = OP_NONE;
  end

  // ===========================================================
  // Operand selection from the source pair field
  assign acc_a = {data_reg[IDX_A_EXT][7:0], data_reg[1], data_reg[0]};
  assign acc_b = {data_reg[IDX_B_EXT][7:0], data_reg[4], data_reg[3]};
  always_comb
  begin
    case (low_byte[5:4])
      2'h0: word_ext = {{8{data_reg[6][23]}}, data_reg[6], 24'h000000};
      2'h1: word_ext = {{8{data_reg[8][23]}}, data_reg[8], 24'h000000};
      2'h2: word_ext = {{8{data_reg[7][23]}}, data_reg[7], 24'h000000};
      default: word_ext = {{8{data_reg[9][23]}}, data_reg[9], 24'h000000};
    endcase
    // Stale extension bits are used as they stand
    s2_sel = low_byte[3] ? acc_b : acc_a;
    if (low_byte[6])
      s1_sel = word_ext;
    else
      s1_sel = low_byte[3] ? acc_a : acc_b;
  end

  // Busy time is the base cost plus the move's extra cycles
  assign total_next = BASE_CYCLES + 5'(pwdata[MOVE_CYC_LSB+3:MOVE_CYC_LSB]);
  assign start = wr_acc && paddr == OFS_INSTR && state_reg == ST_IDLE && op_dec != OP_NONE;

  // ===========================================================
  // Sequencer: exec counts the cost down, done commits results
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (start)
          begin
            state_reg <= ST_EXEC;
            cnt_reg <= total_reg - 5'h01;
          end
        ST_EXEC:
          if (cnt_reg <= 5'h01)
            state_reg <= ST_DONE;
          else
            cnt_reg <= cnt_reg - 5'h01;
        ST_DONE:
          state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Instruction latch and operand capture for the compare unit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_reg <= 24'h000000;
      op_reg <= OP_NONE;
      dsel_reg <= 1'b0;
      load_reg <= 1'b0;
      s1_reg <= 56'h0;
      s2_reg <= 56'h0;
      illegal_reg <= 1'b0;
      words_reg <= BASE_WORDS;
    end
    else
    begin
      load_reg <= start;
      if (wr_acc && paddr == OFS_INSTR && state_reg == ST_IDLE)
      begin
        instr_reg <= pwdata[23:0];
        illegal_reg <= (op_dec == OP_NONE);
      end
      if (start)
      begin
        op_reg <= op_dec;
        dsel_reg <= low_byte[3];
        s1_reg <= s1_sel;
        s2_reg <= s2_sel;
        words_reg <= BASE_WORDS + 2'(move_reg[MOVE_EXT_BIT]);
      end
    end
  end
  assign alu.load = load_reg;
  assign alu.kind = op_reg;
  assign alu.s1 = s1_reg;
  assign alu.s2 = s2_reg;
  assign alu.scale = scale_reg;

  // Move descriptor: limit seen by the parallel move and its cost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      move_reg <= 6'h00;
      total_reg <= BASE_CYCLES;
      scale_reg <= SC_NONE;
    end
    else if (wr_acc && state_reg == ST_IDLE)
    begin
      if (paddr == OFS_MOVE)
      begin
        move_reg <= pwdata[5:0];
        total_reg <= total_next;
      end
      if (paddr == OFS_SCALE && pwdata[1:0] != 2'h3)
        scale_reg <= accu_scale_t'(pwdata[1:0]);
    end
  end

  // ===========================================================
  // Data words; the clear wins over software while busy
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DATA; gi++)
    begin : g_data
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          data_reg[gi] <= 24'h000000;
        else if (done && op_reg == OP_CLR && (gi / 3) == int'(dsel_reg) && gi < 6)
          data_reg[gi] <= 24'h000000;
        else if (wr_acc && data_hit && data_idx == 4'(gi) && state_reg == ST_IDLE)
          data_reg[gi] <= (gi == 2 || gi == 5) ? {16'h0000, pwdata[7:0]} : pwdata[23:0];
      end
    end
  endgenerate

  // ===========================================================
  // Condition flags; hardware update beats a software write
  always_comb
  begin
    flags_next = flags_reg;
    if (done && op_reg == OP_CLR)
    begin
      flags_next[5:1] = 5'b01010;
      flags_next[FLAG_L] = flags_reg[FLAG_L] | move_reg[MOVE_LIMIT_BIT];
    end
    else if (cmp_done)
    begin
      flags_next[5:0] = alu.flags;
      flags_next[FLAG_L] = flags_reg[FLAG_L] | move_reg[MOVE_LIMIT_BIT] | alu.flags[FLAG_V];
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_reg <= FLAGS_RESET;
    else if (done)
      flags_reg <= flags_next;
    else if (wr_acc && paddr == OFS_FLAGS)
      flags_reg <= pwdata[6:0];
  end

  // ===========================================================
  // Interrupts: sticky status, set wins over a clear
  assign irq_events[IRQ_DONE] = done;
  assign irq_events[IRQ_OVF] = cmp_done & alu.flags[FLAG_V];
  assign irq_events[IRQ_ILLEGAL] = wr_acc && paddr == OFS_INSTR && state_reg == ST_IDLE && op_dec == OP_NONE;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_reg <= '0;
      irq_en_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      if (wr_acc && paddr == OFS_IRQ_CLR)
        irq_stat_reg <= (irq_stat_reg & ~pwdata[NUM_IRQ-1:0]) | irq_events;
      else
        irq_stat_reg <= irq_stat_reg | irq_events;
      if (wr_acc && paddr == OFS_IRQ_EN)
        irq_en_reg <= pwdata[NUM_IRQ-1:0];
      irq_reg <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // ===========================================================
  // Read mux; clear register reads as zero
  always_comb
  begin
    rd_data = 32'h00000000;
    if (data_hit)
      rd_data = {8'h00, data_reg[data_idx]};
    else
      case (paddr)
        OFS_INSTR: rd_data = {8'h00, instr_reg};
        OFS_MOVE: rd_data = {26'h0, move_reg};
        OFS_FLAGS: rd_data = {25'h0, flags_reg};
        OFS_STATUS: rd_data = {20'h0, words_reg, 3'h0, total_reg, illegal_reg, state_reg != ST_IDLE};
        OFS_SCALE: rd_data = {30'h0, scale_reg};
        OFS_IRQ_STAT: rd_data = {29'h0, irq_stat_reg};
        OFS_IRQ_EN: rd_data = {29'h0, irq_en_reg};
        default: rd_data = 32'h00000000;
      endcase
  end

  // Answer is registered in the setup cycle, ready in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      valid_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~mapped;
      if (rd_acc)
        prdata_reg <= rd_data;
      valid_reg <= done;
    end
  end
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign condition_flags = flags_reg;
  assign flags_valid = valid_reg;

  // ===========================================================
  // Checks
  logic [4:0] busy_len;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_len <= 5'h00;
    else if (state_reg == ST_IDLE)
      busy_len <= 5'h00;
    else
      busy_len <= busy_len + 5'h01;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence clr_done_s;
    done && op_reg == OP_CLR;
  endsequence
  sequence cmp_done_s;
    cmp_done;
  endsequence
  clr_zero_a: assert property (clr_done_s ##0 !dsel_reg |=> acc_a == 56'h0)
    else $error("first accumulator not cleared");
  clr_flags_a: assert property (clr_done_s |=> flags_reg[5:1] == 5'b01010)
    else $error("clear left wrong flags");
  exec_len_a: assert property (done |-> busy_len + 5'h01 == total_reg)
    else $error("busy time differs from base plus move cycles");
  cmp_keep_a: assert property (cmp_done_s |=> acc_a == $past(acc_a) && acc_b == $past(acc_b))
    else $error("compare altered an accumulator");
  cmp_neg_a: assert property (cmp_done_s |=> flags_reg[FLAG_N] == $past(alu.flags[FLAG_N]))
    else $error("negative flag not taken from difference");
  lim_ovf_a: assert property (cmp_done_s ##0 alu.flags[FLAG_V] |=> flags_reg[FLAG_L])
    else $error("overflow did not set limit flag");
  lim_sticky_a: assert property (flags_reg[FLAG_L] && !(wr_acc && paddr == OFS_FLAGS) |=> flags_reg[FLAG_L])
    else $error("limit flag dropped without software");
  irq_level_a: assert property (irq_en_reg[IRQ_DONE] && done |-> ##2 irq)
    else $error("enabled event did not raise interrupt");
  apb_ready_a: assert property (setup |=> pready ##1 !pready)
    else $error("ready not a single access cycle");
endmodule : accu_clear_compare

// ==== verilog/accu_pkg.sv ====
// Constants and types of the accumulator clear and compare unit
// Behaviour
// - Clear zeroes all 56 bits of accumulator chosen by opcode bit 3.
// - Clear sets U and Z, clears E N V, L only from move limiting.
// - Each operation runs alongside an independent parallel data move.
// - Optional extension word follows; upper opcode bits hold the move field.
// - Two cycles plus move cycles; one word plus the extension word.
// - Compare subtracts source one from source two, keeps only flags.
// - Word source gets 24 low zeros and sign extension to 56 bits.
// - Borrow uses source two accumulator exactly as stored, uncorrected.
// - Magnitude compare subtracts absolute values, updates flags only.
// - N is difference bit 55; Z set when difference is zero.
// - C is carry or borrow out of bit 55; V on overflow.
// - L set by move limiting or overflow, otherwise left unchanged.
// - E and U follow the difference under the active scaling mode.
package accu_pkg;
  // ===========================================================
  // Register map, byte addresses
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_MOVE = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_SCALE = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN = 8'h1c;
  localparam logic [7:0] OFS_DATA = 8'h20;
  // Data words: first acc low/mid/ext, second acc low/mid/ext, x low, x high, y low, y high
  localparam int NUM_DATA = 10;
  localparam logic [3:0] IDX_A_EXT = 4'h2;
  localparam logic [3:0] IDX_B_EXT = 4'h5;
  // ===========================================================
  // Flag positions inside condition_flags
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_U = 4;
  localparam int FLAG_E = 5;
  localparam int FLAG_L = 6;
  localparam logic [6:0] FLAGS_RESET = 7'h00;
  // ===========================================================
  // Move register fields
  localparam int MOVE_LIMIT_BIT = 0;
  localparam int MOVE_CYC_LSB = 1;
  localparam int MOVE_EXT_BIT = 5;
  // Cost of one instruction
  localparam logic [4:0] BASE_CYCLES = 5'h02;
  localparam logic [1:0] BASE_WORDS = 2'h1;
  // ===========================================================
  // Interrupt sources
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVF = 1;
  localparam int IRQ_ILLEGAL = 2;
  localparam int NUM_IRQ = 3;
  // ===========================================================
  // Operation kinds and scaling modes
  typedef enum logic [1:0] {OP_NONE = 2'h0, OP_CLR = 2'h1, OP_CMP = 2'h2, OP_MAG = 2'h3} accu_op_t;
  typedef enum logic [1:0] {SC_NONE = 2'h0, SC_DOWN = 2'h1, SC_UP = 2'h2} accu_scale_t;
  // Gray coded along idle, exec, done
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_DONE = 2'b11} accu_state_t;
endpackage : accu_pkg

// ==== verilog/accu_alu_if.sv ====
// Operand and flag carrier between control and compare unit
`timescale 1ns/10ps
interface accu_alu_if;
  import accu_pkg::*;
  logic load;
  accu_op_t kind;
  logic [55:0] s1;
  logic [55:0] s2;
  accu_scale_t scale;
  logic [5:0] flags;
  modport ctrl (output load, kind, s1, s2, scale, input flags);
  modport unit (input load, kind, s1, s2, scale, output flags);
endinterface : accu_alu_if

// ==== verilog/accu_cmp_unit.sv ====
// Subtractor and flag generator for both compare forms
`timescale 1ns/10ps
module accu_cmp_unit
(
  input wire logic pclk,
  input wire logic presetn,
  accu_alu_if.unit alu
);
  import accu_pkg::*;
  logic [55:0] a_op;
  logic [55:0] b_op;
  logic [56:0] diff;
  logic ovf;
  logic ext_use;
  logic unnorm;
  logic [5:0] flags_reg;

  // ===========================================================
  // Operand shaping: magnitudes for the magnitude form
  always_comb
  begin
    a_op = alu.s2;
    b_op = alu.s1;
    if (alu.kind == OP_MAG)
    begin
      a_op = alu.s2[55] ? 56'(-alu.s2) : alu.s2;
      b_op = alu.s1[55] ? 56'(-alu.s1) : alu.s1;
    end
  end

  // Extra top bit catches the borrow out of bit 55
  assign diff = {1'b0, a_op} - {1'b0, b_op};
  assign ovf = (a_op[55] ^ b_op[55]) & (diff[55] ^ a_op[55]);

  // ===========================================================
  // Scaling moves the binary point the E and U tests look at
  always_comb
  begin
    case (alu.scale)
      SC_DOWN:
      begin
        ext_use = ~((&diff[55:48]) | ~(|diff[55:48]));
        unnorm = ~(diff[48] ^ diff[47]);
      end
      SC_UP:
      begin
        ext_use = ~((&diff[55:46]) | ~(|diff[55:46]));
        unnorm = ~(diff[46] ^ diff[45]);
      end
      default:
      begin
        ext_use = ~((&diff[55:47]) | ~(|diff[55:47]));
        unnorm = ~(diff[47] ^ diff[46]);
      end
    endcase
  end

  // Result is caught once per instruction and held
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_reg <= 6'h00;
    else if (alu.load)
    begin
      flags_reg[FLAG_C] <= diff[56];
      flags_reg[FLAG_V] <= ovf;
      flags_reg[FLAG_Z] <= ~(|diff[55:0]);
      flags_reg[FLAG_N] <= diff[55];
      flags_reg[FLAG_U] <= unnorm;
      flags_reg[FLAG_E] <= ext_use;
    end
  end
  assign alu.flags = flags_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  cmp_zero_a: assert property (alu.load |=> flags_reg[FLAG_Z] == ($past(a_op) == $past(b_op)))
    else $error("zero flag does not match equality");
  cmp_borrow_a: assert property (alu.load |=> flags_reg[FLAG_C] == ($past(a_op) < $past(b_op)))
    else $error("carry flag does not match unsigned borrow");
endmodule : accu_cmp_unit

// ==== tb/accu_apb_master.sv ====
// APB master model standing in for the instruction sequencer
`timescale 1ns/10ps
module accu_apb_master
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ==========================================================
  // Idle bus from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // ==========================================================
  // One transfer: setup, then access held until pready at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait count is assumed; the bench watchdog ends a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so a stale value cannot pass as good
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : accu_apb_master

// ==== tb/accu_clear_compare_test.sv ====
// Self-checking bench of the accumulator clear and compare unit
`timescale 1ns/10ps
module accu_clear_compare_test;
  import accu_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, flags_valid, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_val;
  logic [31:0] seed = 32'h57412655;
  logic [6:0] condition_flags, old_flags;
  logic [31:0] dat [NUM_DATA];
  logic [3:0] p;
  int k;
  int tnum = 0;
  int bad_count = 0;
  int checks_done = 0;

  // ==========================================================
  // Clock and parts
  always #10 pclk = ~pclk;

  accu_clear_compare dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .condition_flags(condition_flags), .flags_valid(flags_valid));

  accu_apb_master m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, rd_val, err);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    m.xfer(1'b0, a, 32'h0, rd_val, err);
  endtask : rd

  function automatic logic [55:0] acc(input int b);
    return {dat[b + 2][7:0], dat[b + 1][23:0], dat[b][23:0]};
  endfunction : acc

  // Word sources get zeros below and sign extension above
  function automatic logic [55:0] src1(input logic [3:0] q);
    logic [31:0] w;
    w = dat[6 + {q[1], q[2]}];
    if (!q[3])
      return q[0] ? acc(0) : acc(3);
    return {{8{w[23]}}, w[23:0], 24'h0};
  endfunction : src1

  // Source two is used as stored, so a stale extension shows in C
  function automatic logic [6:0] expect_flags(input int kd, input logic [3:0] q, input logic [1:0] sc,
    input logic lim);
    logic [55:0] a, b, d;
    logic [56:0] r;
    logic v;
    int s;
    logic signed [55:0] t;
    a = src1(q);
    b = q[0] ? acc(3) : acc(0);
    if (kd == 1)
      return {old_flags[6] | lim, 5'b01010, old_flags[0]};
    if (kd == 3)
    begin
      a = a[55] ? -a : a;
      b = b[55] ? -b : b;
    end
    r = {1'b0, b} - {1'b0, a};
    d = r[55:0];
    v = (a[55] != b[55]) && (d[55] != b[55]);
    s = (sc == 2'h1) ? 48 : (sc == 2'h2) ? 46 : 47;
    t = $signed(d) >>> s;
    return {old_flags[6] | lim | v, t != 0 && t != -1, ~(d[s] ^ d[s - 1]), d[55], d == 0, v, r[56]};
  endfunction : expect_flags

  // ==========================================================
  // One instruction with its move settings, then every result
  task automatic run_op(input int kd, input logic [3:0] q, input logic [1:0] sc, input logic [3:0] cy,
    input logic lim, input logic ext);
    logic [6:0] ef;
    logic [7:0] op;
    int n;
    for (int i = 0; i < NUM_DATA; i++)
      wr(OFS_DATA + 8'(4 * i), dat[i]);
    wr(OFS_MOVE, {26'h0, ext, cy, lim});
    wr(OFS_SCALE, {30'h0, sc});
    ef = expect_flags(kd, q, sc, lim);
    op = (kd == 1) ? {4'h1, q[0], 3'b011} : {1'b0, q, 1'b1, kd == 3, 1'b1};
    wr(OFS_INSTR, {8'h0, 16'(rnd()), op});
    n = 0;
    while (flags_valid !== 1'b1 && n < 40)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(n, 32'(cy) + 2);
    chk(condition_flags, ef);
    rd(OFS_STATUS);
    chk(rd_val & 32'hc7d, {20'h0, 2'(1 + ext), 3'h0, 5'(2 + cy), 2'h0});
    rd(OFS_FLAGS);
    chk(rd_val & 32'h7f, ef);
    for (int i = 0; i < 6; i++)
    begin
      rd(OFS_DATA + 8'(4 * i));
      chk(rd_val, (kd == 1 && q[0] == (i > 2)) ? 32'h0 : dat[i] & ((i % 3 == 2) ? 32'hff : 32'hffffff));
    end
    old_flags = ef;
    $display("test %0d done", tnum);
    tnum++;
  endtask : run_op

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Watchdog, far beyond the expected few thousand cycles
  initial
  begin
    #400000;
    bad_count++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    old_flags = FLAGS_RESET;
    rd(OFS_FLAGS);
    chk(rd_val, 32'(FLAGS_RESET));
    // Unmapped and unaligned places answer with an error
    rd(8'h48);
    chk(err, 1'b1);
    rd(8'h02);
    chk(err, 1'b1);
    // Equal zero operands with the done interrupt masked
    dat = '{default: 32'h0};
    wr(OFS_IRQ_EN, 32'h0);
    run_op(2, 4'h0, 2'h0, 4'h0, 1'b0, 1'b0);
    chk(irq, 1'b0);
    rd(OFS_IRQ_STAT);
    chk(rd_val[0], 1'b1);
    wr(OFS_IRQ_EN, 32'h1);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1);
    wr(OFS_IRQ_CLR, 32'h7);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    // Most negative source one wraps in the magnitude; longest move
    for (int j = 0; j < NUM_DATA; j++)
      dat[j] = rnd();
    dat[0] = 32'h0;
    dat[1] = 32'h0;
    dat[2] = 32'h80;
    run_op(3, 4'h1, 2'h1, 4'hf, 1'b1, 1'b1);
    run_op(1, 4'h1, 2'h2, 4'h1, 1'b0, 1'b0);
    // A refused operand pair leaves the flags alone
    wr(OFS_INSTR, 32'h25);
    rd(OFS_STATUS);
    chk(rd_val[1], 1'b1);
    rd(OFS_IRQ_STAT);
    chk(rd_val[2], 1'b1);
    chk(condition_flags, old_flags);
    // Random mix, with the sticky limit flag cleared now and then
    for (int i = 0; i < 40; i++)
    begin
      for (int j = 0; j < NUM_DATA; j++)
        dat[j] = rnd();
      if (i % 8 == 7)
      begin
        wr(OFS_FLAGS, 32'h0);
        old_flags = 7'h0;
      end
      k = rnd() % 3 + 1;
      p = 4'(rnd());
      if (k > 1 && !p[3])
        p[2:1] = 2'h0;
      run_op(k, p, 2'(rnd() % 3), 4'(rnd()), rnd() % 4 == 0, 1'(rnd()));
    end
    print_verdict();
  end
endmodule : accu_clear_compare_test
